/* rtl/sdr_map.svh */
// constants for the superscalar dispatch and retire control
//
// Summary of operation
// - dispatch only from instr queue slots zero, one
// - two non-branch dispatches per cycle, plus branch
// - one new instruction per unit per cycle
// - target unit needs a free slot
// - rename register for every destination operand
// - no free retire slot, instruction waits
// - simple integer results usable next cycle
// - multiply and divide only on full unit
// - multiply and divide hold full unit several cycles
// - exception cancels younger work, redirects fetch
// - two retire per cycle, slots zero/one, ordered
// - instruction queue has six entries
// - retire queue has six entries
// - retire at end of last complete cycle
// - dispatch takes no cycle of its own
// - retire slot given at dispatch, kept till retire
// - float three stages, load/store pipelined
// - load/store may wait before write-back
// - fetch stage ends at dispatch
// - execute spans dispatch until leaving unit
// - dispatch strictly in program order
// - only link/count branches take retire slot
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// ----------------------------------------------------------------
// queue sizes and rates
// ----------------------------------------------------------------
`define SDR_IQ_DEPTH      6
`define SDR_CQ_DEPTH      6
`define SDR_DISP_SLOTS    2
`define SDR_RETIRE_SLOTS  2
`define SDR_NONBR_MAX     2
`define SDR_FETCH_MAX     4

// ----------------------------------------------------------------
// unit timing
// ----------------------------------------------------------------
`define SDR_FPU_STAGES    3
`define SDR_LSU_STAGES    2
`define SDR_INT_STAGES    1
`define SDR_MULDIV_CYCLES 4

// ----------------------------------------------------------------
// widths and unit indices
// ----------------------------------------------------------------
`define SDR_ID_W          4
`define SDR_CNT_W         3
`define SDR_NUM_TRK       5
`define SDR_NUM_UNITS     6
`define SDR_U_FULL        0
`define SDR_U_SIMPLE      1
`define SDR_U_FLOAT       2
`define SDR_U_LSU         3
`define SDR_U_SYS         4
`define SDR_U_BRANCH      5

`endif

/* rtl/sdr_pkg.sv */
// types shared by the dispatch and retire control
`include "sdr_map.svh"

package sdr_pkg;

	typedef enum logic [2:0] {
		SDR_CLS_INT,
		SDR_CLS_MULDIV,
		SDR_CLS_FLOAT,
		SDR_CLS_LS,
		SDR_CLS_SYS,
		SDR_CLS_BR_LINK,
		SDR_CLS_BR_PLAIN
	} sdr_class_t;

	typedef enum logic {
		SDR_RUN,
		SDR_WAIT
	} sdr_mode_t;

	typedef struct packed {
		logic                 v;
		sdr_class_t           cls;
		logic [1:0]           dests;
	} sdr_iq_ent_t;

	typedef struct packed {
		logic                 v;
		logic                 done;
		logic                 exc;
		logic [1:0]           dests;
		logic [`SDR_ID_W-1:0] id;
	} sdr_cq_ent_t;

	typedef struct packed {
		logic                  v;
		logic [`SDR_ID_W-1:0]  id;
		logic [`SDR_CNT_W-1:0] cnt;
	} sdr_stage_t;

endpackage

/* rtl/sdr_unit_track.sv */
// occupancy tracker of one execution unit pipeline
`timescale 1ns/10ps
`include "sdr_map.svh"

module sdr_unit_track
	import sdr_pkg::*;
#(
	parameter int STAGES = 1
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// issue from dispatch
	input  wire logic                  issue,
	input  wire logic [`SDR_ID_W-1:0]  issue_id,
	input  wire logic [`SDR_CNT_W-1:0] issue_cycles,
	// unit side
	input  wire logic                  ext_hold,
	input  wire logic                  flush,
	// status
	output logic                       vacant,
	output logic                       finish,
	output logic [`SDR_ID_W-1:0]       finish_id
);

	typedef struct packed {
		sdr_stage_t [STAGES-1:0] st;
	} sdr_trk_state_t;

	sdr_trk_state_t s;
	sdr_trk_state_t nx;
	logic [STAGES-1:0] moving;

	// ----------------------------------------------------------------
	// stage movement
	// ----------------------------------------------------------------
	always_comb begin
		nx = s;
		moving[STAGES-1] = s.st[STAGES-1].v && (s.st[STAGES-1].cnt == '0) && !ext_hold;
		for (int i = STAGES - 2; i >= 0; i--) begin
			moving[i] = s.st[i].v && (!s.st[i+1].v || moving[i+1]);
		end
		if (s.st[STAGES-1].v && s.st[STAGES-1].cnt != '0) begin
			nx.st[STAGES-1].cnt = s.st[STAGES-1].cnt - 1'b1;
		end
		for (int i = 0; i < STAGES; i++) begin
			if (moving[i]) begin
				nx.st[i].v = 1'b0;
			end
		end
		for (int i = 1; i < STAGES; i++) begin
			if (moving[i-1]) begin
				nx.st[i] = s.st[i-1];
			end
		end
		if (issue) begin
			nx.st[0].v = 1'b1;
			nx.st[0].id = issue_id;
			nx.st[0].cnt = issue_cycles;
		end
		if (flush) begin
			nx = '0;
		end
		vacant = !s.st[0].v || moving[0];
		finish = moving[STAGES-1];
		finish_id = s.st[STAGES-1].id;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= nx;
		end
	end

endmodule // sdr_unit_track

/* rtl/sdr_dispatch_retire.sv */
// dispatch, retire queue and exception flush of the master pipeline
`timescale 1ns/10ps
`include "sdr_map.svh"

module sdr_dispatch_retire
	import sdr_pkg::*;
#(
	parameter int IQ_D   = `SDR_IQ_DEPTH,
	parameter int CQ_D   = `SDR_CQ_DEPTH,
	parameter int FETCH  = `SDR_FETCH_MAX,
	parameter int REN_W  = 3
) (
	// clock and reset
	input  wire logic                                    clock,
	input  wire logic                                    rst,
	// fetcher
	input  wire logic [2:0]                              fetch_count,
	input  wire sdr_class_t [FETCH-1:0]                  fetch_cls,
	input  wire logic [FETCH-1:0][1:0]                   fetch_dests,
	output logic [2:0]                                   iq_free_count,
	output logic                                         fetch_redirect,
	// rename registers
	input  wire logic [REN_W-1:0]                        rename_free,
	output logic [2:0]                                   rename_alloc,
	output logic [2:0]                                   rename_commit,
	output logic                                         rename_discard,
	// execution units
	input  wire logic [`SDR_NUM_TRK-1:0]                 unit_hold,
	input  wire logic [`SDR_NUM_TRK-1:0]                 unit_exc,
	output logic [`SDR_NUM_UNITS-1:0]                    disp_valid,
	output logic [`SDR_NUM_UNITS-1:0][`SDR_ID_W-1:0]     disp_id,
	output logic [`SDR_NUM_TRK-1:0]                      unit_done,
	output logic                                         pipe_flush,
	// retirement
	output logic [`SDR_RETIRE_SLOTS-1:0]                 retire_valid,
	output logic [`SDR_RETIRE_SLOTS-1:0][`SDR_ID_W-1:0]  retire_id
);

	// tracked units exclude the branch unit, which has no pipe
	localparam int NT = `SDR_NUM_TRK;
	localparam int NU = `SDR_NUM_UNITS;
	localparam int BR = `SDR_U_BRANCH;

	// the block state apart from the unit trackers, outputs included, in one register
	typedef struct packed {
		sdr_iq_ent_t [IQ_D-1:0]                      iq;
		sdr_cq_ent_t [CQ_D-1:0]                      cq;
		logic [`SDR_ID_W-1:0]                        next_id;
		sdr_mode_t                                   mode;
		logic [2:0]                                  iq_free;
		logic [NU-1:0]                               disp_v;
		logic [NU-1:0][`SDR_ID_W-1:0]                disp_id;
		logic [NT-1:0]                               done;
		logic [2:0]                                  ren_alloc;
		logic [2:0]                                  ren_commit;
		logic                                        ren_discard;
		logic                                        redirect;
		logic                                        flush;
		logic [`SDR_RETIRE_SLOTS-1:0]                ret_v;
		logic [`SDR_RETIRE_SLOTS-1:0][`SDR_ID_W-1:0] ret_id;
	} sdr_state_t;

	sdr_state_t s;
	sdr_state_t nx;

	logic [NU-1:0]                unit_free;
	logic [NT-1:0]                trk_fin;
	logic [NT-1:0][`SDR_ID_W-1:0] trk_fin_id;
	logic [`SDR_CNT_W-1:0]        muldiv_cyc;

	sdr_cq_ent_t [CQ_D-1:0] cq_w;
	sdr_cq_ent_t [CQ_D-1:0] cq_n;
	sdr_iq_ent_t [IQ_D-1:0] iq_n;
	logic [NU-1:0]          used;
	logic                   go;
	logic                   ok;
	logic                   need_cq;
	logic                   exc_hit;
	int                     ret_n;
	int                     pop;
	int                     nonbr;
	int                     cq_top;
	int                     iq_top;
	int                     ren_left;
	int                     ren_ret;
	int                     ren_use;
	int                     tgt;

	// ----------------------------------------------------------------
	// execution unit trackers
	// ----------------------------------------------------------------
	// the branch unit resolves at once, so it is always free
	assign unit_free[BR] = 1'b1;

	// trackers are fed from nx so a unit owns its instruction from the
	// dispatch edge itself; a registered issue would cost a cycle
	generate
		for (genvar g = 0; g < NT; g++) begin : g_trk
			// float and load/store are deeper pipes
			localparam int ST = (g == `SDR_U_FLOAT) ? `SDR_FPU_STAGES :
			                    (g == `SDR_U_LSU)   ? `SDR_LSU_STAGES : `SDR_INT_STAGES;
			sdr_unit_track #(
				.STAGES       (ST)
			) u_trk (
				.clock        (clock),
				.rst          (rst),
				.issue        (nx.disp_v[g]),
				.issue_id     (nx.disp_id[g]),
				.issue_cycles ((g == `SDR_U_FULL) ? muldiv_cyc : '0),
				// memory waits stretch the last stage
				.ext_hold     (unit_hold[g]),
				.flush        (nx.flush),
				.vacant       (unit_free[g]),
				.finish       (trk_fin[g]),
				.finish_id    (trk_fin_id[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nx = s;
		// every pulse drops unless set again below
		nx.disp_v = '0;
		nx.ret_v = '0;
		nx.redirect = 1'b0;
		nx.flush = 1'b0;
		nx.ren_discard = 1'b0;
		nx.ren_alloc = '0;
		// finish pulse one cycle after the tracker finish
		nx.done = trk_fin;
		// scratch values of this pass
		cq_w = s.cq;
		cq_n = '0;
		iq_n = '0;
		used = '0;
		exc_hit = 1'b0;
		ok = 1'b0;
		need_cq = 1'b0;
		ret_n = 0;
		pop = 0;
		nonbr = 0;
		cq_top = 0;
		iq_top = 0;
		ren_ret = 0;
		ren_use = 0;
		ren_left = int'(rename_free);
		tgt = 0;
		muldiv_cyc = '0;

		// units report finish into their retire entries
		// status counts only in the finish cycle, so units need not hold it
		for (int k = 0; k < CQ_D; k++) begin
			for (int u = 0; u < NT; u++) begin
				if (trk_fin[u] && s.cq[k].v && s.cq[k].id == trk_fin_id[u]) begin
					cq_w[k].done = 1'b1;
					cq_w[k].exc = unit_exc[u];
				end
			end
		end

		// oldest two entries, stop at first not done
		// retire only on entries already marked done
		// an entry that is not done stops the one behind it
		go = (s.mode == SDR_RUN);
		for (int k = 0; k < `SDR_RETIRE_SLOTS; k++) begin
			if (go && s.cq[k].v && s.cq[k].done) begin
				if (s.cq[k].exc) begin
					exc_hit = 1'b1;
					go = 1'b0;
				end else begin
					nx.ret_v[k] = 1'b1;
					nx.ret_id[k] = s.cq[k].id;
					ren_ret = ren_ret + int'(s.cq[k].dests);
					ret_n = ret_n + 1;
				end
			end else begin
				go = 1'b0;
			end
		end
		nx.ren_commit = 3'(ren_ret);

		// the excepting entry is dropped, never shown as retired;
		// fetches offered in this cycle are lost as well
		if (exc_hit) begin
			nx.cq = '0;
			nx.iq = '0;
			nx.redirect = 1'b1;
			nx.flush = 1'b1;
			nx.ren_discard = 1'b1;
			nx.mode = SDR_WAIT;
			nx.iq_free = 3'(IQ_D);
		end else begin
			for (int k = 0; k < CQ_D; k++) begin
				if (k + ret_n < CQ_D) begin
					cq_n[k] = cq_w[k+ret_n];
				end
				if (cq_n[k].v) begin
					cq_top = k + 1;
				end
			end

			// only the two lowest entries are looked at
			// a refused slot blocks the one behind it
			go = (s.mode == SDR_RUN);
			for (int k = 0; k < `SDR_DISP_SLOTS; k++) begin
				if (go && s.iq[k].v) begin
					ok = 1'b1;
					need_cq = 1'b1;
					case (s.iq[k].cls)
						// plain integer prefers the simple unit
						SDR_CLS_INT: begin
							if (unit_free[`SDR_U_SIMPLE] && !used[`SDR_U_SIMPLE]) begin
								tgt = `SDR_U_SIMPLE;
							end else begin
								tgt = `SDR_U_FULL;
							end
						end
						// multiply and divide steered to full unit
						SDR_CLS_MULDIV: tgt = `SDR_U_FULL;
						SDR_CLS_FLOAT: tgt = `SDR_U_FLOAT;
						SDR_CLS_LS: tgt = `SDR_U_LSU;
						SDR_CLS_SYS: tgt = `SDR_U_SYS;
						SDR_CLS_BR_LINK: tgt = BR;
						// plain branches take no retire slot
						SDR_CLS_BR_PLAIN: begin
							tgt = BR;
							need_cq = 1'b0;
						end
						default: begin
							tgt = BR;
							ok = 1'b0;
						end
					endcase
					// one per unit, unit must have room
					ok = ok && unit_free[tgt] && !used[tgt];
					// branch is on top of the two others
					ok = ok && (tgt == BR || nonbr < `SDR_NONBR_MAX);
					// slots freed by this cycle's retirement are already counted
					// stays queued without a retire slot
					ok = ok && (!need_cq || cq_top < CQ_D);
					ok = ok && (int'(s.iq[k].dests) <= ren_left);
					if (ok) begin
						used[tgt] = 1'b1;
						pop = pop + 1;
						if (tgt != BR) begin
							nonbr = nonbr + 1;
						end
						// unit takes it at the same edge
						nx.disp_v[tgt] = 1'b1;
						nx.disp_id[tgt] = nx.next_id;
						ren_left = ren_left - int'(s.iq[k].dests);
						ren_use = ren_use + int'(s.iq[k].dests);
						if (s.iq[k].cls == SDR_CLS_MULDIV) begin
							// several cycles in execute
							// only the full unit ever sees a nonzero count
							muldiv_cyc = `SDR_CNT_W'(`SDR_MULDIV_CYCLES - 1);
						end
						if (need_cq) begin
							// slot given now, held until retire
							cq_n[cq_top].v = 1'b1;
							cq_n[cq_top].done = (tgt == BR);
							cq_n[cq_top].exc = 1'b0;
							cq_n[cq_top].dests = s.iq[k].dests;
							cq_n[cq_top].id = nx.next_id;
							cq_top = cq_top + 1;
							// plain branches show the tag without using it up
							nx.next_id = nx.next_id + 1'b1;
						end
					end else begin
						go = 1'b0;
					end
				end else begin
					go = 1'b0;
				end
			end
			nx.cq = cq_n;
			nx.ren_alloc = 3'(ren_use);

			// resume once redirected work has arrived
			// retire is idle in wait mode too; the queue is empty then
			if (s.mode == SDR_WAIT && s.iq[0].v) begin
				nx.mode = SDR_RUN;
			end

			// dispatched entries leave the fetch queue
			// dispatch pops first, then new fetches fill behind
			for (int k = 0; k < IQ_D; k++) begin
				if (k + pop < IQ_D) begin
					iq_n[k] = s.iq[k+pop];
				end
				if (iq_n[k].v) begin
					iq_top = k + 1;
				end
			end
			// new fetches fill the six entries in order
			for (int j = 0; j < FETCH; j++) begin
				if (j < int'(fetch_count) && iq_top < IQ_D) begin
					iq_n[iq_top].v = 1'b1;
					iq_n[iq_top].cls = fetch_cls[j];
					iq_n[iq_top].dests = fetch_dests[j];
					iq_top = iq_top + 1;
				end
			end
			nx.iq = iq_n;
			nx.iq_free = 3'(IQ_D - iq_top);
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
			// queue starts empty, so every entry is free
			s.iq_free <= 3'(IQ_D);
		end else begin
			s <= nx;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// every output is a plain copy of the state register
	assign iq_free_count  = s.iq_free;
	assign fetch_redirect = s.redirect;
	assign rename_alloc   = s.ren_alloc;
	assign rename_commit  = s.ren_commit;
	assign rename_discard = s.ren_discard;
	assign disp_valid     = s.disp_v;
	assign disp_id        = s.disp_id;
	assign unit_done      = s.done;
	assign pipe_flush     = s.flush;
	assign retire_valid   = s.ret_v;
	assign retire_id      = s.ret_id;

endmodule // sdr_dispatch_retire

/* dv/sdr_far_model.sv */
// far side model: unit stalls, exception status and rename pool
`timescale 1ns/10ps

module sdr_far_model (
	// clock and reset
	input  wire logic	clock,
	input  wire logic	rst,
	// bench control
	input  wire logic	calm,
	input  wire logic	starve,
	input  wire logic	exc_arm,
	// toward the design
	output logic [4:0]	unit_hold,
	output logic [4:0]	unit_exc,
	output logic [2:0]	rename_free
);
	logic [4:0]	rnd_hold;
	logic [2:0]	rnd_free;

	initial begin
		rnd_hold = 5'h00;
		rnd_free = 3'h7;
	end
	// each unit stalls about one cycle in four, like a busy memory side
	always @(posedge clock) begin
		#1;
		rnd_hold = 5'($urandom & $urandom);
		rnd_free = 3'($urandom);
	end
	// combinational so bench mode changes act without an extra edge
	assign unit_hold = (calm || rst) ? 5'h00 : rnd_hold;
	assign rename_free = starve ? 3'h0 : (calm ? 3'h7 : rnd_free);
	// status only counts at finish, so it is held while armed
	assign unit_exc = exc_arm ? 5'h1f : 5'h00;
endmodule // sdr_far_model

/* dv/sdr_dr_asserts.sv */
// checker of the dispatch and retire control ports
`timescale 1ns/10ps
`include "sdr_map.svh"

module sdr_dr_asserts #(
	parameter int REN_W = 3
) (
	// clock and reset
	input  wire logic	clock,
	input  wire logic	rst,
	// watched ports
	input  wire logic [REN_W-1:0]	rename_free,
	input  wire logic [4:0]	unit_hold,
	input  wire logic [5:0]	disp_valid,
	input  wire logic [4:0]	unit_done,
	input  wire logic	pipe_flush,
	input  wire logic	fetch_redirect,
	input  wire logic	rename_discard,
	input  wire logic [2:0]	rename_alloc,
	input  wire logic [1:0]	retire_valid,
	input  wire logic [1:0][3:0]	retire_id
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_float_go;
		disp_valid[2] && !pipe_flush;
	endsequence
	sequence s_float_free;
		(!unit_hold[2] && !pipe_flush)[*4];
	endsequence

	two_disp_max_a: assert property ($countones(disp_valid[4:0]) <= 2)
		else $error("more than two non-branch dispatches");
	retire_in_order_a: assert property (retire_valid[1] |->
		retire_valid[0] && retire_id[1] == (retire_id[0] + 4'h1))
		else $error("retire slots out of order");
	flush_together_a: assert property (pipe_flush == fetch_redirect
		&& pipe_flush == rename_discard)
		else $error("flush pulses apart");
	flush_pulse_a: assert property (pipe_flush |=> !pipe_flush)
		else $error("flush longer than one cycle");
	resume_wait_a: assert property (pipe_flush |=> (disp_valid == 6'h00)[*2])
		else $error("dispatch too soon after flush");
	flush_no_retire_a: assert property (pipe_flush |->
		!retire_valid[1] ##1 retire_valid == 2'b00)
		else $error("younger work retired");
	rename_room_a: assert property (rename_alloc <= $past(rename_free))
		else $error("rename overdrawn");
	alloc_with_disp_a: assert property (rename_alloc != 3'h0 |-> disp_valid != 6'h00)
		else $error("rename taken without dispatch");
	int_one_cycle_a: assert property (disp_valid[1] && !unit_hold[1] |=>
		unit_done[1] || pipe_flush)
		else $error("simple integer not done next cycle");
	float_three_a: assert property (s_float_go ##0 s_float_free |-> unit_done[2])
		else $error("float not done after three stages");
endmodule // sdr_dr_asserts

bind sdr_dispatch_retire sdr_dr_asserts #(.REN_W(REN_W)) u_chk (
	.clock(clock), .rst(rst), .rename_free(rename_free), .unit_hold(unit_hold),
	.disp_valid(disp_valid), .unit_done(unit_done), .pipe_flush(pipe_flush),
	.fetch_redirect(fetch_redirect), .rename_discard(rename_discard),
	.rename_alloc(rename_alloc), .retire_valid(retire_valid), .retire_id(retire_id));

/* dv/tb.sv */
// testbench of the dispatch and retire control
`timescale 1ns/10ps
`include "sdr_map.svh"

module tb;
	import sdr_pkg::*;
	logic	clock, rst, calm, starve, exc_arm, stop;
	logic [2:0]	fetch_count, iq_free_count, rename_free, rename_alloc, rename_commit;
	sdr_class_t [3:0]	fetch_cls;
	logic [3:0][1:0]	fetch_dests;
	logic	fetch_redirect, rename_discard, pipe_flush;
	logic [4:0]	unit_hold, unit_exc, unit_done;
	logic [5:0]	disp_valid;
	logic [5:0][3:0]	disp_id;
	logic [1:0]	retire_valid;
	logic [1:0][3:0]	retire_id;
	logic [3:0]	exp_tag;
	logic [15:0]	ret_cnt, exp_ret, ren_a, ren_c, exp_ren;
	int	fail_count, check_count, n, gap, u;

	sdr_dispatch_retire dut (.clock(clock), .rst(rst), .fetch_count(fetch_count),
		.fetch_cls(fetch_cls), .fetch_dests(fetch_dests), .iq_free_count(iq_free_count),
		.fetch_redirect(fetch_redirect), .rename_free(rename_free),
		.rename_alloc(rename_alloc), .rename_commit(rename_commit),
		.rename_discard(rename_discard), .unit_hold(unit_hold), .unit_exc(unit_exc),
		.disp_valid(disp_valid), .disp_id(disp_id), .unit_done(unit_done),
		.pipe_flush(pipe_flush), .retire_valid(retire_valid), .retire_id(retire_id));
	sdr_far_model u_far (.clock(clock), .rst(rst), .calm(calm), .starve(starve),
		.exc_arm(exc_arm), .unit_hold(unit_hold), .unit_exc(unit_exc),
		.rename_free(rename_free));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic test_done();
		if (fail_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [5:0] unit_of(sdr_class_t c);
		case (c)
			SDR_CLS_INT: return 6'h02;
			SDR_CLS_MULDIV: return 6'h01;
			SDR_CLS_FLOAT: return 6'h04;
			SDR_CLS_LS: return 6'h08;
			SDR_CLS_SYS: return 6'h10;
			default: return 6'h20;
		endcase
	endfunction
	task automatic cyc();
		@(posedge clock);
		#1;
	endtask
	// offers beyond the free count are dropped; the count stands until changed
	task automatic send(int k);
		fetch_count = 3'(k);
		for (int j = 0; j < k && j < iq_free_count; j++) begin
			exp_ret += (fetch_cls[j] != SDR_CLS_BR_PLAIN);
			exp_ren += fetch_dests[j];
		end
		cyc();
	endtask
	task automatic offer(int k, sdr_class_t c, logic [1:0] d);
		for (int j = 0; j < 4; j++) fetch_cls[j] = c;
		fetch_dests = {4{d}};
		send(k);
		fetch_count = 3'h0;
	endtask

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		#3000000;
		fail_count++;
		test_done();
	end
	// retirement watch on the falling edge, where outputs are settled
	always @(negedge clock) begin
		if (!rst && !stop) begin
			ren_a += rename_alloc;
			ren_c += rename_commit;
			for (int k = 0; k < 2; k++) begin
				if (retire_valid[k] === 1'b1) begin
					chk("retire_id", 16'(exp_tag), 16'(retire_id[k]));
					exp_tag++;
					ret_cnt++;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, calm, starve, exc_arm, stop} = 5'b11000;
		fetch_count = 3'h0;
		for (int j = 0; j < 4; j++) fetch_cls[j] = SDR_CLS_INT;
		fetch_dests = 8'h00;
		{exp_tag, ret_cnt, exp_ret, ren_a, ren_c, exp_ren} = '0;
		void'($urandom(16));
		repeat (4) @(posedge clock);
		#1;
		rst = 1'b0;
		chk("iq_free_count", 16'h6, 16'(iq_free_count));
		chk("disp_valid", 16'h0, 16'(disp_valid));
		cyc();
		starve = 1'b1;
		offer(4, SDR_CLS_INT, 2'h1);
		chk("iq_free_count", 16'h2, 16'(iq_free_count));
		cyc();
		offer(4, SDR_CLS_INT, 2'h1);
		chk("iq_free_count", 16'h0, 16'(iq_free_count));
		chk("disp_valid", 16'h0, 16'(disp_valid));
		starve = 1'b0;
		cyc();
		chk("disp_valid", 16'h03, 16'(disp_valid));
		repeat (8) cyc();
		chk("iq_free_count", 16'h6, 16'(iq_free_count));
		for (int c = 0; c < 7; c++) begin
			offer(1, sdr_class_t'(c), (c < 5) ? 2'h1 : 2'h0);
			cyc();
			chk("disp_valid", 16'(unit_of(sdr_class_t'(c))), 16'(disp_valid));
			u = $clog2(unit_of(sdr_class_t'(c)));
			chk("disp_id", 16'(exp_tag), 16'(disp_id[u]));
			repeat (8) cyc();
		end
		offer(3, SDR_CLS_FLOAT, 2'h1);
		for (int i = 0; i < 3; i++) begin
			cyc();
			chk("disp_valid", 16'h04, 16'(disp_valid));
		end
		repeat (6) cyc();
		offer(2, SDR_CLS_MULDIV, 2'h1);
		cyc();
		gap = 0;
		do begin
			cyc();
			gap++;
		end while (disp_valid[0] !== 1'b1 && gap < 20);
		chk("muldiv gap", 16'(`SDR_MULDIV_CYCLES), 16'(gap));
		calm = 1'b0;
		repeat (400) begin
			n = $urandom % 5;
			// the fetcher never offers more than the queue reports free
			if (n > iq_free_count) begin
				n = iq_free_count;
			end
			for (int j = 0; j < 4; j++) begin
				fetch_cls[j] = sdr_class_t'(3'($urandom % 7));
				fetch_dests[j] = (fetch_cls[j] >= SDR_CLS_BR_LINK) ? 2'h0
					: 2'($urandom % 3);
			end
			send(n);
		end
		calm = 1'b1;
		fetch_count = 3'h0;
		repeat (40) cyc();
		chk("iq_free_count", 16'h6, 16'(iq_free_count));
		chk("retired", exp_ret, ret_cnt);
		chk("rename alloc", exp_ren, ren_a);
		chk("rename commit", exp_ren, ren_c);
		stop = 1'b1;
		exc_arm = 1'b1;
		offer(2, SDR_CLS_INT, 2'h1);
		for (int i = 0; i < 20 && pipe_flush !== 1'b1; i++) cyc();
		exc_arm = 1'b0;
		chk("fetch_redirect", 16'h1, 16'(fetch_redirect));
		chk("rename_discard", 16'h1, 16'(rename_discard));
		chk("iq_free_count", 16'h6, 16'(iq_free_count));
		offer(2, SDR_CLS_INT, 2'h1);
		chk("disp_valid", 16'h0, 16'(disp_valid));
		cyc();
		chk("disp_valid", 16'h0, 16'(disp_valid));
		cyc();
		chk("disp_valid", 16'h03, 16'(disp_valid));
		repeat (10) cyc();
		test_done();
	end
endmodule // tb
